// *** cbt_bit_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cbt_regs.svh"
module cbt_bit_timer (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // time quantum enable
  input  wire logic            tq_tick,
  // timing configuration
  input  wire logic [2:0]      prop_seg_len,
  input  wire logic [2:0]      phase1_len,
  input  wire logic [2:0]      phase2_len,
  input  wire logic            phase2_free_sel,
  input  wire logic            triple_sample_sel,
  input  wire logic            wake_line_filter_sel,
  // bus line pin
  input  wire logic            can_rx,
  // results
  output logic                 sample_pulse,
  output logic                 sample_bit,
  output logic                 bit_end,
  output logic                 wake_req,
  output cbt_pkg::cbt_seg_type seg_state
);
  import cbt_pkg::*;

  // ----------------------------------------
  // line synchroniser and filter
  // ----------------------------------------
  logic       rx_s1_reg, rx_s2_reg, rx_s3_reg; // pin sync chain
  logic       line_reg;                        // accepted line level
  logic       line_prev_reg;                   // for raw edge
  logic [7:0] low_cnt_reg;                     // dominant run length

  // three flops; change only when second and third agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
      line_reg  <= 1'b1;
    end else begin
      rx_s1_reg <= can_rx;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg) begin
        line_reg <= rx_s3_reg;
      end
    end
  end

  // ----------------------------------------
  // wake detection
  // ----------------------------------------
  // filtered mode ignores glitches shorter than the wake time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_reg   <= 8'h00;
      line_prev_reg <= 1'b1;
      wake_req      <= 1'b0;
    end else begin
      line_prev_reg <= line_reg;
      if (line_reg) begin
        low_cnt_reg <= 8'h00;
      end else if (low_cnt_reg != 8'(`CBT_WAKE_CNT)) begin
        low_cnt_reg <= low_cnt_reg + 8'h01;
      end
      if (wake_line_filter_sel) begin
        wake_req <= !line_reg && (low_cnt_reg == 8'(`CBT_WAKE_CNT - 1));
      end else begin
        wake_req <= line_prev_reg && !line_reg;
      end
    end
  end

  // ----------------------------------------
  // segment sequencer
  // ----------------------------------------
  cbt_seg_type seg_reg, seg_next;  // current segment
  cbt_len_type tq_cnt_reg;         // quanta spent in segment
  cbt_len_type ph1_eff, ph2_eff;   // effective phase lengths
  cbt_len_type seg_len;            // length of current segment
  logic        seg_last;           // last quantum of segment
  logic [2:0]  hist_reg;           // line at recent quanta

  // phase 2 free or derived from phase 1 and processing time
  always_comb begin
    ph1_eff = cbt_len_f(phase1_len);
    if (phase2_free_sel) begin
      ph2_eff = cbt_len_f(phase2_len);
    end else begin
      ph2_eff = (ph1_eff > `CBT_IPT_TQ) ? ph1_eff : `CBT_IPT_TQ;
    end
    case (seg_reg)
      BT_SYNC: seg_len = 4'h1;
      BT_PROP: seg_len = cbt_len_f(prop_seg_len);
      BT_PH1:  seg_len = ph1_eff;
      BT_PH2:  seg_len = ph2_eff;
      default: seg_len = 4'h1;
    endcase
    // >= keeps a shortened length from stalling mid segment
    seg_last = tq_tick && (tq_cnt_reg >= seg_len - 4'h1);
    case (seg_reg)
      BT_SYNC: seg_next = BT_PROP;
      BT_PROP: seg_next = BT_PH1;
      BT_PH1:  seg_next = BT_PH2;
      BT_PH2:  seg_next = BT_SYNC;
      default: seg_next = BT_SYNC;
    endcase
  end

  // segment and quantum counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_reg    <= BT_SYNC;
      tq_cnt_reg <= 4'h0;
    end else if (seg_last) begin
      seg_reg    <= seg_next;
      tq_cnt_reg <= 4'h0;
    end else if (tq_tick) begin
      tq_cnt_reg <= tq_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // sampling at end of phase 1
  // ----------------------------------------
  // triple mode votes the last three quanta up to the point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_reg     <= 3'h7;
      sample_pulse <= 1'b0;
      sample_bit   <= 1'b1;
      bit_end      <= 1'b0;
    end else begin
      sample_pulse <= seg_last && (seg_reg == BT_PH1);
      bit_end      <= seg_last && (seg_reg == BT_PH2);
      if (tq_tick) begin
        hist_reg <= {hist_reg[1:0], line_reg};
      end
      if (seg_last && (seg_reg == BT_PH1)) begin
        if (triple_sample_sel) begin
          sample_bit <= (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & line_reg) | (hist_reg[0] & line_reg);
        end else begin
          sample_bit <= line_reg;
        end
      end
    end
  end

  assign seg_state = seg_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] seg_ticks_reg; // helper: quanta in segment
  logic [5:0] bit_ticks_reg; // helper: quanta in bit
  logic [10:0] cfg_now;      // helper: timing config as one word
  logic [10:0] cfg_prev_reg; // helper: config one cycle ago
  logic        cfg_dirty_reg; // helper: config moved during this bit

  assign cfg_now = {triple_sample_sel, phase2_free_sel, phase2_len, phase1_len, prop_seg_len};

  // a bit that saw a config write has mixed lengths, so length checks skip it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_prev_reg  <= 11'h000;
      cfg_dirty_reg <= 1'b0;
    end else begin
      cfg_prev_reg <= cfg_now;
      // a change wins over the clear at the end of a bit
      if (cfg_now != cfg_prev_reg) begin
        cfg_dirty_reg <= 1'b1;
      end else if (bit_end) begin
        cfg_dirty_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_ticks_reg <= 5'h00;
      bit_ticks_reg <= 6'h00;
    end else if (tq_tick) begin
      seg_ticks_reg <= seg_last ? 5'h00 : seg_ticks_reg + 5'h01;
      bit_ticks_reg <= (seg_last && seg_reg == BT_PH2) ? 6'h00 : bit_ticks_reg + 6'h01;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  prop_len_a: assert property (!cfg_dirty_reg && $stable(cfg_now) &&
    seg_reg == BT_PH1 && $past(seg_reg) == BT_PROP |->
    $past(seg_ticks_reg) + 5'h01 == {1'b0, cbt_len_f(prop_seg_len)}) else $error("prop length wrong");
  ph1_len_a: assert property (!cfg_dirty_reg && $stable(cfg_now) &&
    seg_reg == BT_PH2 && $past(seg_reg) == BT_PH1 |->
    $past(seg_ticks_reg) + 5'h01 == {1'b0, cbt_len_f(phase1_len)}) else $error("phase1 length wrong");
  ph2_free_a: assert property (!cfg_dirty_reg && $stable(cfg_now) &&
    phase2_free_sel && seg_reg == BT_SYNC && $past(seg_reg) == BT_PH2 |->
    $past(seg_ticks_reg) + 5'h01 == {1'b0, cbt_len_f(phase2_len)}) else $error("phase2 free length wrong");
  ph2_max_a: assert property (!cfg_dirty_reg && $stable(cfg_now) &&
    !phase2_free_sel && seg_reg == BT_SYNC && $past(seg_reg) == BT_PH2 |->
    $past(seg_ticks_reg) + 5'h01 >= {1'b0, `CBT_IPT_TQ}) else $error("phase2 below processing time");
  bit_len_a: assert property (!cfg_dirty_reg && $stable(cfg_now) &&
    bit_end |-> ##0 $past(bit_ticks_reg) + 6'h01 ==
    6'h01 + {2'b0, cbt_len_f(prop_seg_len)} + {2'b0, ph1_eff} + {2'b0, ph2_eff}) else $error("bit length wrong");
  single_smp_a: assert property (sample_pulse && !$past(triple_sample_sel) |->
    sample_bit == $past(line_reg)) else $error("single sample wrong");
  wake_filt_a: assert property (wake_req && $past(wake_line_filter_sel) |->
    $past(low_cnt_reg) == 8'(`CBT_WAKE_CNT - 1)) else $error("filtered wake too early");
  wake_raw_a: assert property (wake_req && !$past(wake_line_filter_sel) |->
    $past(line_reg, 2) && !$past(line_reg)) else $error("raw wake without edge");

  bit_done_c: cover property (bit_end);
  triple_c: cover property (sample_pulse && triple_sample_sel);
  wake_c: cover property (wake_req && wake_line_filter_sel);
endmodule
`default_nettype wire

// *** cbt_can_node.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// other node on the shared bus line
// ----------------------------------------
module cbt_can_node (
  // clock
  input  wire logic pclk,
  // bus line as the device sees it
  output var logic  can_rx
);
  // bus is pulled recessive while no node drives it
  initial can_rx = 1'b1;

  // dominant run of n clocks, then back to recessive
  task automatic low_for(input int n);
    @(posedge pclk);
    can_rx <= 1'b0;
    repeat (n) @(posedge pclk);
    can_rx <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** cbt_pkg.sv ***
`default_nettype none
package cbt_pkg;
  // bit segment states, gray along the bit
  typedef enum logic [1:0] {
    BT_SYNC = 2'b00,
    BT_PROP = 2'b01,
    BT_PH1  = 2'b11,
    BT_PH2  = 2'b10
  } cbt_seg_type;

  // segment length in time quanta
  typedef logic [3:0] cbt_len_type;

  // three-bit length code to quanta, code plus one
  function automatic cbt_len_type cbt_len_f(input logic [2:0] code);
    return {1'b0, code} + 4'h1;
  endfunction
endpackage
`default_nettype wire

// *** cbt_regs.svh ***
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CBT_BTC_OFS      12'h000
`define CBT_FEN_OFS      12'h004
`define CBT_BPL_OFS      12'h008
`define CBT_BPM_OFS      12'h00c
`define CBT_STAT_OFS     12'h010
// ----------------------------------------
// bit timing field positions
// ----------------------------------------
`define CBT_WAKE_BIT     14
`define CBT_PH2_MSB      10
`define CBT_PH2_LSB      8
`define CBT_FREE_BIT     7
`define CBT_TRIPLE_BIT   6
`define CBT_PH1_MSB      5
`define CBT_PH1_LSB      3
`define CBT_PROP_MSB     2
`define CBT_PROP_LSB     0
`define CBT_BTC_RW_MASK  16'h47ff
// ----------------------------------------
// reset values
// ----------------------------------------
`define CBT_BTC_RST      16'h0000
`define CBT_FEN_RST      16'hffff
`define CBT_BP_RST       16'h0000
// ----------------------------------------
// pointer encoding and timing
// ----------------------------------------
`define CBT_FIFO_PTR     4'hf
`define CBT_IPT_TQ       4'h2
`define CBT_CLK_MHZ      50
`define CBT_TQ_NS        100
`define CBT_TQ_DIV       ((`CBT_TQ_NS * `CBT_CLK_MHZ) / 1000)
`define CBT_WAKE_NS      500
`define CBT_WAKE_CNT     ((`CBT_WAKE_NS * `CBT_CLK_MHZ + 999) / 1000)
`endif

// *** cbt_testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cbt_regs.svh"
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, route_buf_idx, p;
  logic        can_rx, route_valid, route_to_fifo, sample_pulse, sample_bit, bit_end, wake_req;
  logic [15:0] filter_hit, accept_hit;
  logic [2:0]  route_filter;
  int          bad_count, samples_checked, per, tail, w0;
  int          wake_n = 0;
  // pointer pair {mid, lo}: fifo, buffer 14 and buffer 0 all appear
  logic [31:0] bp = 32'h9c3ffe10;
  // timing word, bit length and sample-to-end span in clocks
  logic [15:0] cfg [4] = '{16'h0000, 16'h0391, 16'h0011, 16'h07bf};
  int          exp_per [4] = '{25, 50, 45, 125};
  int          exp_tail [4] = '{10, 20, 15, 40};

  cbt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .can_rx(can_rx), .filter_hit(filter_hit), .accept_hit(accept_hit),
    .route_valid(route_valid), .route_to_fifo(route_to_fifo), .route_buf_idx(route_buf_idx),
    .route_filter(route_filter), .sample_pulse(sample_pulse), .sample_bit(sample_bit),
    .bit_end(bit_end), .wake_req(wake_req));
  cbt_can_node node (.pclk(pclk), .can_rx(can_rx));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // wake pulses counted, one per detected event
  always @(posedge pclk) if (wake_req === 1'b1) wake_n <= wake_n + 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits on pready, never assumes a count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic hit(input logic [15:0] h);
    @(posedge pclk);
    filter_hit <= h;
    @(posedge pclk);
    filter_hit <= 16'h0000;
    #1;
  endtask

  task automatic wait_end;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (bit_end !== 1'b1 && n < 300);
  endtask

  // second full bit after a change, first may be stretched
  task automatic measure;
    int s;
    s = 0;
    per = 0;
    wait_end;
    wait_end;
    do begin
      @(posedge pclk);
      #1;
      per++;
      if (sample_pulse === 1'b1) s = per;
    end while (bit_end !== 1'b1 && per < 300);
    tail = per - s;
  endtask

  task automatic summarize;
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog, far beyond the thousand or so clocks the run needs
  initial begin
    #400000;
    bad_count++;
    summarize;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, filter_hit} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CBT_FEN_OFS, 32'h0); chk(rd, 32'h0000ffff);
    apb(1'b0, `CBT_BPL_OFS, 32'h0); chk(rd, 32'h00000000);
    apb(1'b1, `CBT_BTC_OFS, 32'hffffffff);
    apb(1'b0, `CBT_BTC_OFS, 32'h0); chk(rd, 32'h000047ff);
    apb(1'b0, 12'h020, 32'h0); chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, `CBT_BPL_OFS, {16'h0, bp[15:0]});
    apb(1'b1, `CBT_BPM_OFS, {16'h0, bp[31:16]});
    apb(1'b0, `CBT_BPM_OFS, 32'h0); chk(rd, {16'h0, bp[31:16]});
    // every filter 0..7 routed through its own field
    for (int i = 0; i < 8; i++) begin
      p = bp[4*i +: 4];
      hit(16'h1 << i);
      chk(32'({route_valid, route_to_fifo, route_filter, route_buf_idx}), 32'({1'b1, p == 4'hf, 3'(i), p}));
      chk(32'(accept_hit), 32'h1 << i);
    end
    // filter 0 repointed to the fifo
    apb(1'b1, `CBT_BPL_OFS, {16'h0, bp[15:4], 4'hf});
    hit(16'h0001); chk(32'({route_valid, route_to_fifo, route_filter, route_buf_idx}), 32'h18f);
    apb(1'b1, `CBT_FEN_OFS, 32'hfff7);
    hit(16'h0008); chk(32'({route_valid, accept_hit}), 32'h0);
    hit(16'h0028); chk(32'({route_valid, route_to_fifo, route_filter, route_buf_idx}), 32'h153);
    apb(1'b0, `CBT_STAT_OFS, 32'h0); chk(rd & 32'h000001ff, 32'h00000053);
    hit(16'h1000); chk(32'({route_valid, accept_hit}), 32'h01000);
    // segment lengths, free and derived phase 2
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `CBT_BTC_OFS, {16'h0, cfg[k]});
      apb(1'b0, `CBT_BTC_OFS, 32'h0); chk(rd, {16'h0, cfg[k]});
      measure;
      chk(32'(per), 32'(exp_per[k]));
      chk(32'(tail), 32'(exp_tail[k]));
    end
    // filtered wake, triple sampling of a dominant run
    apb(1'b1, `CBT_BTC_OFS, 32'h4040);
    w0 = wake_n;
    node.low_for(60);
    #1;
    chk(32'(sample_bit), 32'h0);
    repeat (60) @(posedge pclk);
    #1;
    chk(32'(sample_bit), 32'h1);
    chk(32'(wake_n - w0), 32'h1);
    w0 = wake_n;
    node.low_for(10);
    repeat (40) @(posedge pclk);
    chk(32'(wake_n - w0), 32'h0);
    // raw wake: short run still wakes
    apb(1'b1, `CBT_BTC_OFS, 32'h0);
    w0 = wake_n;
    node.low_for(10);
    repeat (40) @(posedge pclk);
    chk(32'(wake_n - w0), 32'h1);
    summarize;
  end
endmodule
`default_nettype wire

// *** cbt_top.sv ***
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "cbt_regs.svh"
// Functional notes
// - wake select routes line through filter
// - bits 13 to 11 read zero
// - phase 2 length is code plus one
// - phase 2 free or max(phase1, processing)
// - triple or single sample at point
// - phase 1 length is code plus one
// - propagation length is code plus one
// - one enable bit per filter
// - pointer 1111 routes to receive FIFO
// - pointer 0 to 14 selects buffer
// - first pointer register holds filters 3..0
// - second pointer register holds filters 7..4
module cbt_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // bus line pin
  input  wire logic        can_rx,
  // acceptance comparator hits
  input  wire logic [15:0] filter_hit,
  // routing result
  output logic [15:0]      accept_hit,
  output logic             route_valid,
  output logic             route_to_fifo,
  output logic [3:0]       route_buf_idx,
  output logic [2:0]       route_filter,
  // bit timing results
  output logic             sample_pulse,
  output logic             sample_bit,
  output logic             bit_end,
  output logic             wake_req
);
  import cbt_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] bit_timing_config_b_reg;      // bit timing
  logic [15:0] filter_enable_set_reg;        // filter enables
  logic [15:0] filter_buffer_select_lo_reg;  // pointers 3..0
  logic [15:0] filter_buffer_select_mid_reg; // pointers 7..4
  logic [31:0] status_word;                  // live state
  cbt_seg_type seg_state;                    // timer segment
  logic        wr_en;                        // write access phase
  logic        rd_setup;                     // read setup phase
  logic        addr_ok;                      // mapped address

  // write merge under byte strobes, low lanes only
  function automatic logic [15:0] cbt_merge_f(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
    logic [15:0] res;
    res = old;
    if (st[0]) begin
      res[7:0] = wd[7:0];
    end
    if (st[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // address decode
  function automatic logic cbt_hit_f(input logic [11:0] a);
    return (a == `CBT_BTC_OFS) || (a == `CBT_FEN_OFS) || (a == `CBT_BPL_OFS) ||
           (a == `CBT_BPM_OFS) || (a == `CBT_STAT_OFS);
  endfunction

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign addr_ok  = cbt_hit_f(paddr);
  assign pslverr  = psel && penable && !addr_ok;
  assign wr_en    = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;

  // register writes, one process per register group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_timing_config_b_reg <= `CBT_BTC_RST;
    end else if (wr_en && paddr == `CBT_BTC_OFS) begin
      // unused bits never store
      bit_timing_config_b_reg <= cbt_merge_f(bit_timing_config_b_reg, pwdata, pstrb) & `CBT_BTC_RW_MASK;
    end
  end

  // filters all enabled after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_enable_set_reg <= `CBT_FEN_RST;
    end else if (wr_en && paddr == `CBT_FEN_OFS) begin
      filter_enable_set_reg <= cbt_merge_f(filter_enable_set_reg, pwdata, pstrb);
    end
  end

  // buffer pointer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_buffer_select_lo_reg  <= `CBT_BP_RST;
      filter_buffer_select_mid_reg <= `CBT_BP_RST;
    end else if (wr_en) begin
      if (paddr == `CBT_BPL_OFS) begin
        filter_buffer_select_lo_reg <= cbt_merge_f(filter_buffer_select_lo_reg, pwdata, pstrb);
      end
      if (paddr == `CBT_BPM_OFS) begin
        filter_buffer_select_mid_reg <= cbt_merge_f(filter_buffer_select_mid_reg, pwdata, pstrb);
      end
    end
  end

  // live status: segment, last sample, last route
  assign status_word = {20'h00000, seg_state, sample_bit, route_valid, route_to_fifo,
                        route_filter, route_buf_idx};

  // read data captured in setup so it is a flop during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        `CBT_BTC_OFS:  prdata <= {16'h0000, bit_timing_config_b_reg & `CBT_BTC_RW_MASK};
        `CBT_FEN_OFS:  prdata <= {16'h0000, filter_enable_set_reg};
        `CBT_BPL_OFS:  prdata <= {16'h0000, filter_buffer_select_lo_reg};
        `CBT_BPM_OFS:  prdata <= {16'h0000, filter_buffer_select_mid_reg};
        `CBT_STAT_OFS: prdata <= status_word;
        default:       prdata <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------
  // time quantum divider
  // ----------------------------------------
  logic [7:0] tq_div_reg; // clocks within one quantum
  logic       tq_tick;    // one-cycle quantum enable

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_div_reg <= 8'h00;
    end else if (tq_div_reg == 8'(`CBT_TQ_DIV - 1)) begin
      tq_div_reg <= 8'h00;
    end else begin
      tq_div_reg <= tq_div_reg + 8'h01;
    end
  end

  assign tq_tick = (tq_div_reg == 8'(`CBT_TQ_DIV - 1));

  // ----------------------------------------
  // bit timing engine
  // ----------------------------------------
  cbt_bit_timer u_timer (
    .pclk                 (pclk),
    .presetn              (presetn),
    .tq_tick              (tq_tick),
    .prop_seg_len         (bit_timing_config_b_reg[`CBT_PROP_MSB:`CBT_PROP_LSB]),
    .phase1_len           (bit_timing_config_b_reg[`CBT_PH1_MSB:`CBT_PH1_LSB]),
    .phase2_len           (bit_timing_config_b_reg[`CBT_PH2_MSB:`CBT_PH2_LSB]),
    .phase2_free_sel      (bit_timing_config_b_reg[`CBT_FREE_BIT]),
    .triple_sample_sel    (bit_timing_config_b_reg[`CBT_TRIPLE_BIT]),
    .wake_line_filter_sel (bit_timing_config_b_reg[`CBT_WAKE_BIT]),
    .can_rx               (can_rx),
    .sample_pulse         (sample_pulse),
    .sample_bit           (sample_bit),
    .bit_end              (bit_end),
    .wake_req             (wake_req),
    .seg_state            (seg_state)
  );

  // ----------------------------------------
  // filter routing
  // ----------------------------------------
  logic [3:0]  buf_ptr [8];  // pointer per low filter
  logic [15:0] gated_hit;    // hits of enabled filters
  logic        pick_valid;   // some low filter hit
  logic [2:0]  pick_filter;  // lowest hitting filter

  // pointer fields from the two registers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ptr
      assign buf_ptr[gi]     = filter_buffer_select_lo_reg[4*gi +: 4];
      assign buf_ptr[gi + 4] = filter_buffer_select_mid_reg[4*gi +: 4];
    end
  endgenerate

  // disabled filters are masked before any pick
  assign gated_hit = filter_hit & filter_enable_set_reg;

  // lowest filter number wins when several hit at once
  always_comb begin
    pick_valid  = 1'b0;
    pick_filter = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (gated_hit[i]) begin
        pick_valid  = 1'b1;
        pick_filter = 3'(i);
      end
    end
  end

  // registered routing result, one cycle after the hit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_hit    <= 16'h0000;
      route_valid   <= 1'b0;
      route_to_fifo <= 1'b0;
      route_buf_idx <= 4'h0;
      route_filter  <= 3'h0;
    end else begin
      accept_hit  <= gated_hit;
      route_valid <= pick_valid;
      if (pick_valid) begin
        route_filter  <= pick_filter;
        route_to_fifo <= (buf_ptr[pick_filter] == `CBT_FIFO_PTR);
        route_buf_idx <= buf_ptr[pick_filter];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  rsvd_zero_a: assert property (psel && penable && !pwrite && paddr == `CBT_BTC_OFS |->
    prdata[15] == 1'b0 && prdata[13:11] == 3'h0) else $error("unused timing bits not zero");
  fen_write_a: assert property (wr_en && paddr == `CBT_FEN_OFS && pstrb[1:0] == 2'h3 |=>
    {16'h0000, filter_enable_set_reg} == ($past(pwdata) & 32'h0000ffff)) else $error("enable write lost");
  dis_filter_a: assert property (filter_hit[0] && !filter_enable_set_reg[0] &&
    gated_hit[7:1] == 7'h00 |=> !route_valid) else $error("disabled filter routed");
  fifo_route_a: assert property (gated_hit[0] && buf_ptr[0] == `CBT_FIFO_PTR |=>
    route_valid && route_to_fifo && route_filter == 3'h0) else $error("fifo route missed");
  buf_route_a: assert property (gated_hit[0] && buf_ptr[0] != `CBT_FIFO_PTR |=>
    !route_to_fifo && {12'h000, route_buf_idx} == ($past(filter_buffer_select_lo_reg) & 16'h000f))
    else $error("buffer idx wrong");
  lo_map_a: assert property (gated_hit[7:0] == 8'h08 |=>
    {route_buf_idx, 12'h000} == ($past(filter_buffer_select_lo_reg) & 16'hf000) && route_filter == 3'h3)
    else $error("filter 3 map");
  mid_map_a: assert property (gated_hit[7:0] == 8'h80 |=>
    {route_buf_idx, 12'h000} == ($past(filter_buffer_select_mid_reg) & 16'hf000) && route_filter == 3'h7)
    else $error("filter 7 map");
  // writes leave prdata alone, so only reads must show zero
  unmapped_a: assert property (psel && penable && !addr_ok |-> pslverr && (pwrite || prdata == 32'h00000000))
    else $error("unmapped access not flagged");

  route_fifo_c: cover property (route_valid && route_to_fifo);
  route_buf_c: cover property (route_valid && !route_to_fifo);
endmodule
`default_nettype wire
